/* rtl/pmgs_pkg.sv */
// Package: shared constants and types of the management serial slave
package pmgs_pkg;

  // Register file geometry
  localparam int REG_COUNT = 32;
  localparam int REG_WIDTH = 16;
  localparam int ADDR_WIDTH = 5;
  localparam int STRAP_WIDTH = 4;

  // Frame field codes
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] WRITE_TURN = 2'h2;

  // Bit counts of frame fields
  localparam logic [4:0] ADDR_BITS = 5'h0a;
  localparam logic [4:0] DATA_BITS = 5'h10;

  // Indirect access register addresses
  localparam logic [4:0] IND_CTRL_ADDR = 5'h0d;
  localparam logic [4:0] IND_DATA_ADDR = 5'h0e;

  // Indirect control fields
  localparam int IND_FUNC_MSB = 15;
  localparam int IND_FUNC_LSB = 14;
  localparam int IND_CODE_MSB = 4;
  localparam logic [4:0] EXT_CODE_VENDOR = 5'h1f;
  localparam logic [4:0] EXT_CODE_PMA = 5'h01;
  localparam logic [1:0] FUNC_ADDR = 2'h0;
  localparam logic [1:0] FUNC_DATA = 2'h1;
  localparam logic [1:0] FUNC_INC_RW = 2'h2;
  localparam logic [1:0] FUNC_INC_W = 2'h3;

  // Reset values
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Extended register side: one access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] code;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pmgs_ext_req_t;

  // Decoded header of a frame
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] dev;
    logic [4:0] reg_addr;
  } pmgs_hdr_t;

endpackage

/* rtl/pmgs_edge_sync.sv */
// Synchroniser and rising edge finder for the management clock and data pins
`timescale 1ns/100ps
module pmgs_edge_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc_pin,
  input wire logic mdio_pin,
  output logic mdc_rise,
  output logic mdio_level
);

  logic [1:0] mdc_sync_r; // Two-stage clock sampler
  logic [1:0] mdio_sync_r; // Two-stage data sampler
  logic mdc_prev_r; // Previous settled clock level
  logic [1:0] mdc_sync_nxt;
  logic [1:0] mdio_sync_nxt;
  logic mdc_prev_nxt;

  // Next values of the samplers
  always_comb
  begin
    mdc_sync_nxt = {mdc_sync_r[0], mdc_pin};
    mdio_sync_nxt = {mdio_sync_r[0], mdio_pin};
    mdc_prev_nxt = mdc_sync_r[1];
  end

  // Register the samplers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mdc_sync_r <= 2'h0;
      mdio_sync_r <= 2'h3;
      mdc_prev_r <= 1'b0;
    end
    else
    begin
      mdc_sync_r <= mdc_sync_nxt;
      mdio_sync_r <= mdio_sync_nxt;
      mdc_prev_r <= mdc_prev_nxt;
    end
  end

  // Rising edge only from settled stages
  assign mdc_rise = mdc_sync_r[1] & ~mdc_prev_r;
  assign mdio_level = mdio_sync_r[1];

endmodule

/* rtl/pmgs_slave.sv */
// Management serial slave: frame decoder, 32 direct registers, indirect access
`timescale 1ns/100ps
// Contract
// - Decoding survives stopped management clock
// - Sample on rising edge, drive away
// - Line undriven in idle and first turnaround bit
// - Four-bit station address caught at reset
// - Register field selects one of 32
// - Frame starts only on 01 code
// - Two-bit turnaround before data field
// - Nobody drives first read turnaround bit
// - Read drives zero then data MSB-first
// - Indirect access via registers 0xD, 0xE
// - Only extended codes 11111, 00001 accepted
module pmgs_slave
#(
  parameter int STRAP_W = pmgs_pkg::STRAP_WIDTH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [STRAP_W-1:0] station_address_strap,
  output logic [STRAP_W-1:0] station_address,
  output pmgs_pkg::pmgs_ext_req_t ext_req,
  input wire logic [15:0] ext_rdata
);

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_HDR, ST_TURN, ST_DATA} pmgs_state_t;

  logic mdc_rise; // One-cycle strobe per rising clock edge
  logic mdio_s; // Settled data level

  pmgs_edge_sync u_sync
  (
    .clk(clk),
    .rst(rst),
    .mdc_pin(mdc),
    .mdio_pin(mdio_in),
    .mdc_rise(mdc_rise),
    .mdio_level(mdio_s)
  );

  pmgs_state_t state_r, state_nxt; // Frame decoder state
  logic [4:0] cnt_r, cnt_nxt; // Bit counter within field
  logic [11:0] hdr_r, hdr_nxt; // Opcode, device and register fields
  logic [15:0] shift_r, shift_nxt; // Data shifter
  logic hit_r, hit_nxt; // Frame is for this station, read
  logic mdio_out_r, mdio_out_nxt;
  logic mdio_oe_r, mdio_oe_nxt;
  logic [15:0] regs_r [pmgs_pkg::REG_COUNT]; // Direct register file
  logic wr_en; // Write commit strobe
  logic [15:0] wr_data;
  logic [STRAP_W-1:0] addr_r; // Latched station address
  logic strap_done_r; // Address captured after reset release
  logic [15:0] ind_addr_r, ind_addr_nxt; // Extended address register
  pmgs_pkg::pmgs_ext_req_t ext_r, ext_nxt;
  pmgs_pkg::pmgs_hdr_t hdr;
  logic [15:0] rd_word; // Word presented on a read
  logic code_ok; // Indirect code is a supported one
  logic [1:0] func; // Indirect access function

  assign hdr = pmgs_pkg::pmgs_hdr_t'(hdr_r);
  assign func = regs_r[pmgs_pkg::IND_CTRL_ADDR][pmgs_pkg::IND_FUNC_MSB:pmgs_pkg::IND_FUNC_LSB];

  // Supported extended code check
  function automatic logic ext_code_ok(input logic [4:0] code);
    ext_code_ok = (code == pmgs_pkg::EXT_CODE_VENDOR) || (code == pmgs_pkg::EXT_CODE_PMA);
  endfunction

  assign code_ok = ext_code_ok(regs_r[pmgs_pkg::IND_CTRL_ADDR][pmgs_pkg::IND_CODE_MSB:0]);

  // Read source: indirect data window or direct register
  always_comb
  begin
    rd_word = regs_r[hdr.reg_addr];
    if (hdr.reg_addr == pmgs_pkg::IND_DATA_ADDR)
    begin
      if (!code_ok)
        rd_word = 16'h0000;
      else if (func == pmgs_pkg::FUNC_ADDR)
        rd_word = ind_addr_r;
      else
        rd_word = ext_rdata;
    end
  end

  // Frame decoder next state; advances only on a clock edge, so a stopped clock just waits
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    shift_nxt = shift_r;
    hit_nxt = hit_r;
    mdio_out_nxt = mdio_out_r;
    mdio_oe_nxt = mdio_oe_r;
    wr_en = 1'b0;
    wr_data = shift_r;
    if (mdc_rise)
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          mdio_oe_nxt = 1'b0;
          if (!mdio_s)
            state_nxt = ST_START; // First start bit seen
        end
        ST_START:
        begin
          if (mdio_s)
          begin
            state_nxt = ST_HDR;
            cnt_nxt = 5'h00;
          end
          else
            state_nxt = ST_IDLE;
        end
        ST_HDR:
        begin
          hdr_nxt = {hdr_r[10:0], mdio_s};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == 5'h01 && {hdr_r[0], mdio_s} != pmgs_pkg::OP_READ
              && {hdr_r[0], mdio_s} != pmgs_pkg::OP_WRITE)
            state_nxt = ST_IDLE;
          else if (cnt_r == pmgs_pkg::ADDR_BITS + 5'h01)
          begin
            state_nxt = ST_TURN;
            cnt_nxt = 5'h00;
          end
        end
        ST_TURN:
        begin
          cnt_nxt = cnt_r + 5'h01;
          hit_nxt = (hdr.op == pmgs_pkg::OP_READ)
                    && (hdr.dev == {{(5-STRAP_W){1'b0}}, addr_r});
          if (cnt_r == 5'h00)
          begin
            // Released during first bit; zero driven for the second
            mdio_oe_nxt = hit_nxt;
            mdio_out_nxt = 1'b0;
            shift_nxt = rd_word;
          end
          else
          begin
            state_nxt = ST_DATA;
            cnt_nxt = 5'h00;
            mdio_out_nxt = shift_r[15];
            shift_nxt = {shift_r[14:0], 1'b0};
          end
        end
        ST_DATA:
        begin
          cnt_nxt = cnt_r + 5'h01;
          if (hit_r)
          begin
            mdio_out_nxt = shift_r[15];
            shift_nxt = {shift_r[14:0], 1'b0};
          end
          else
            shift_nxt = {shift_r[14:0], mdio_s};
          if (cnt_r == pmgs_pkg::DATA_BITS - 5'h01)
          begin
            state_nxt = ST_IDLE;
            mdio_oe_nxt = 1'b0;
            hit_nxt = 1'b0;
            wr_data = {shift_r[14:0], mdio_s};
            wr_en = (hdr.op == pmgs_pkg::OP_WRITE)
                    && (hdr.dev == {{(5-STRAP_W){1'b0}}, addr_r});
          end
        end
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  // Indirect access: address register update and extended requests
  always_comb
  begin
    ind_addr_nxt = ind_addr_r;
    ext_nxt = '0;
    ext_nxt.code = regs_r[pmgs_pkg::IND_CTRL_ADDR][pmgs_pkg::IND_CODE_MSB:0];
    ext_nxt.addr = ind_addr_r;
    ext_nxt.wdata = wr_data;
    if (hdr.reg_addr == pmgs_pkg::IND_DATA_ADDR && code_ok)
    begin
      if (wr_en)
      begin
        if (func == pmgs_pkg::FUNC_ADDR)
          ind_addr_nxt = wr_data;
        else
        begin
          ext_nxt.wr = 1'b1;
          if (func != pmgs_pkg::FUNC_DATA)
            ind_addr_nxt = ind_addr_r + 16'h0001;
        end
      end
      else if (mdc_rise && state_r == ST_DATA && hit_r && cnt_r == pmgs_pkg::DATA_BITS - 5'h01
               && func != pmgs_pkg::FUNC_ADDR)
      begin
        ext_nxt.rd = 1'b1; // Read completed
        if (func == pmgs_pkg::FUNC_INC_RW)
          ind_addr_nxt = ind_addr_r + 16'h0001;
      end
    end
  end

  // Decoder, outputs and indirect state registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      hdr_r <= 12'h000;
      shift_r <= 16'h0000;
      hit_r <= 1'b0;
      mdio_out_r <= 1'b0;
      mdio_oe_r <= 1'b0;
      ind_addr_r <= 16'h0000;
      ext_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      shift_r <= shift_nxt;
      hit_r <= hit_nxt;
      mdio_out_r <= mdio_out_nxt;
      mdio_oe_r <= mdio_oe_nxt;
      ind_addr_r <= ind_addr_nxt;
      ext_r <= ext_nxt;
    end
  end

  // Direct register file writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < pmgs_pkg::REG_COUNT; i++)
        regs_r[i] <= pmgs_pkg::REG_RESET;
    end
    else if (wr_en && hdr.reg_addr != pmgs_pkg::IND_DATA_ADDR)
      regs_r[hdr.reg_addr] <= wr_data;
  end

  // Station address strap, caught on the first edge after reset release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_r <= '0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      addr_r <= station_address_strap;
      strap_done_r <= 1'b1;
    end
  end

  assign mdio_out = mdio_out_r;
  assign mdio_oe = mdio_oe_r;
  assign station_address = addr_r;
  assign ext_req = ext_r;

endmodule

/* testbench/pmgs_slave_props.sv */
// Checker of the slave's pin behaviour
`timescale 1ns/100ps
module pmgs_slave_props
#(
  parameter int STRAP_W = 4
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [STRAP_W-1:0] station_address_strap,
  input wire logic [STRAP_W-1:0] station_address,
  input pmgs_pkg::pmgs_ext_req_t ext_req,
  input wire logic [15:0] ext_rdata
);
  logic mdc_d_r;  // Clock pin one cycle ago
  logic [4:0] cnt_r;  // Clock rises while driving
  logic [4:0] cnt_nxt;
  // Count rises, restart when released
  always_comb
  begin
    cnt_nxt = mdio_oe ? cnt_r + {4'h0, mdc && !mdc_d_r} : 5'h00;
  end
  // Register helpers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mdc_d_r <= 1'b0;
      cnt_r <= 5'h00;
    end
    else
    begin
      mdc_d_r <= mdc;
      cnt_r <= cnt_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_strap_latch: assert property (
    !$past(rst) |-> station_address == $past(station_address_strap))
    else $error("station address differs from straps");
  a_oe_rise_timing: assert property (
    $rose(mdio_oe) |-> mdc && $past(mdc, 2)) else $error("drive starts off clock high");
  a_out_change_high: assert property (
    $changed(mdio_out) && mdio_oe && $past(mdio_oe) |-> mdc && $past(mdc, 2))
    else $error("data changes near clock rise");
  a_turn_zero: assert property (
    $rose(mdio_oe) |-> !mdio_out) else $error("turnaround bit not zero");
  a_drive_length: assert property (
    $fell(mdio_oe) |-> cnt_r == 5'h11) else $error("drive not 17 bits long");
  a_write_quiet: assert property (
    ext_req.wr |-> !mdio_oe) else $error("line driven during write");
  a_ext_pulse: assert property (
    ext_req.wr || ext_req.rd |=> !ext_req.wr && !ext_req.rd) else $error("request too long");
  a_ext_code: assert property (
    ext_req.wr || ext_req.rd |-> ext_req.code inside {5'h1f, 5'h01})
    else $error("request with foreign code");
endmodule
bind pmgs_slave pmgs_slave_props #(.STRAP_W(STRAP_W)) pmgs_slave_props_i
(
  .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .station_address_strap(station_address_strap),
  .station_address(station_address), .ext_req(ext_req), .ext_rdata(ext_rdata)
);

/* testbench/pmgs_station.sv */
// Station manager model: clock maker and frame driver
`timescale 1ns/100ps
module pmgs_station
(
  input wire logic clk,
  input wire logic mdio_wire,
  output logic mdc,
  output logic sta_out,
  output logic sta_oe
);
  logic [17:0] rd_bits;  // Last bits sampled on the wire
  initial
  begin
    mdc = 1'b0;
    sta_out = 1'b1;
    sta_oe = 1'b0;
  end
  // One bit: change while clock low, sample at its rise
  task automatic bit_time(input logic drive, input logic val);
    mdc = 1'b0;
    sta_oe = drive;
    sta_out = val;
    repeat (10) @(negedge clk);
    mdc = 1'b1;
    rd_bits = {rd_bits[16:0], mdio_wire};
    repeat (10) @(negedge clk);
  endtask
  // Whole frame with short preamble; clock stops low afterwards
  task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] dev,
    input logic [4:0] ra, input logic [15:0] wd);
    logic [35:0] bits;
    bits = {4'hf, st, op, dev, ra, pmgs_pkg::WRITE_TURN, wd};
    for (int i = 35; i >= 0; i--)
      bit_time(i > 17 || op != pmgs_pkg::OP_READ, bits[i]);
    mdc = 1'b0;
    sta_oe = 1'b0;
  endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench of the management serial slave
`timescale 1ns/100ps
module testbench;
  localparam logic [3:0] STRAP = 4'h5;  // Straps of this device
  localparam logic [15:0] EXT_DATA = 16'h3c96;  // Extended read data
  localparam logic [4:0] ME = 5'h05;  // Own device field
  logic clk;
  logic rst;
  logic mdc;
  logic sta_out;
  logic sta_oe;
  logic mdio_out;
  logic mdio_oe;
  logic mdio_wire;
  logic [3:0] station_address;
  pmgs_pkg::pmgs_ext_req_t ext_req;
  pmgs_pkg::pmgs_ext_req_t ext_seen;  // Last extended request
  int num_errors = 0;
  int n_tests = 0;
  // Device drives, else station, else pull-up
  assign mdio_wire = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);
  pmgs_slave pmgs_slave_i
  (
    .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .station_address_strap(STRAP), .station_address(station_address),
    .ext_req(ext_req), .ext_rdata(EXT_DATA)
  );
  pmgs_station pmgs_station_i
  (
    .clk(clk), .mdio_wire(mdio_wire), .mdc(mdc), .sta_out(sta_out), .sta_oe(sta_oe)
  );
  // Keep each extended request pulse
  always @(posedge clk)
    if (ext_req.wr || ext_req.rd)
      ext_seen <= ext_req;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] dev, input logic [4:0] ra, input logic [15:0] d);
    pmgs_station_i.frame(pmgs_pkg::START_CODE, pmgs_pkg::OP_WRITE, dev, ra, d);
  endtask
  // Read own register: turnaround then data
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    pmgs_station_i.frame(pmgs_pkg::START_CODE, pmgs_pkg::OP_READ, ME, ra, 16'h0000);
    check("turnaround", 16'h0002, {14'h0000, pmgs_station_i.rd_bits[17:16]});
    check("read data", exp, pmgs_station_i.rd_bits[15:0]);
  endtask
  task automatic ind(input logic [15:0] ctrl, input logic [15:0] d);
    wr(ME, pmgs_pkg::IND_CTRL_ADDR, ctrl);
    wr(ME, pmgs_pkg::IND_DATA_ADDR, d);
    check("ext write", {ctrl[4:0], 11'h001}, {ext_seen.code, 10'h000, ext_seen.wr});
    check("ext data", d, ext_seen.wdata);
  endtask
  task automatic t_reset();
    check("station address", {12'h000, STRAP}, {12'h000, station_address});
    check("idle drive", 16'h0000, {15'h0000, mdio_oe});
  endtask
  // Registers 0, 15 and 31 written then read back
  task automatic t_direct();
    rd(5'h07, pmgs_pkg::REG_RESET);
    for (int i = 0; i < 3; i++)
      wr(ME, 5'(i * 31 / 2), 16'ha5c3 + 16'(i));
    for (int i = 0; i < 3; i++)
      rd(5'(i * 31 / 2), 16'ha5c3 + 16'(i));
  endtask
  // Foreign address, bad start and opcodes are ignored
  task automatic t_refuse();
    logic [5:0] ops;
    ops = 6'h32;
    wr(ME ^ 5'h01, 5'h0f, 16'hffff);
    wr(ME | 5'h10, 5'h0f, 16'hffff);
    pmgs_station_i.frame(pmgs_pkg::START_CODE, pmgs_pkg::OP_READ, ME ^ 5'h01, 5'h0f, 16'h0000);
    check("foreign read", 16'hffff, pmgs_station_i.rd_bits[15:0]);
    for (int i = 0; i < 3; i++)
      pmgs_station_i.frame(2'(i > 0), ops[i*2 +: 2], 5'h00, 5'h00, 16'h0000);
    repeat (500) @(negedge clk);
    rd(5'h0f, 16'ha5c4);
  endtask
  task automatic t_indirect();
    wr(ME, pmgs_pkg::IND_CTRL_ADDR, 16'h001f);
    wr(ME, pmgs_pkg::IND_DATA_ADDR, 16'h0042);
    rd(pmgs_pkg::IND_DATA_ADDR, 16'h0042);
    ind(16'h401f, 16'h1234);
    check("ext addr", 16'h0042, ext_seen.addr);
    rd(pmgs_pkg::IND_DATA_ADDR, EXT_DATA);
    ind(16'h801f, 16'h1111);
    ind(16'h801f, 16'h2222);
    check("ext addr", 16'h0043, ext_seen.addr);
    ind(16'hc01f, 16'h3333);
    check("ext addr", 16'h0044, ext_seen.addr);
    rd(pmgs_pkg::IND_DATA_ADDR, EXT_DATA);
    check("ext read", {5'h1f, 11'h001}, {ext_seen.code, 10'h000, ext_seen.rd});
    check("ext read addr", 16'h0045, ext_seen.addr);
    ind(16'h4001, 16'h5678);
    check("ext addr", 16'h0045, ext_seen.addr);
    wr(ME, pmgs_pkg::IND_CTRL_ADDR, 16'h4003);
    wr(ME, pmgs_pkg::IND_DATA_ADDR, 16'h9999);
    check("ext data", 16'h5678, ext_seen.wdata);
    rd(pmgs_pkg::IND_DATA_ADDR, 16'h0000);
  endtask
  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial
  begin
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    t_reset();
    t_direct();
    t_refuse();
    t_indirect();
    print_verdict();
  end
endmodule
